//--- logic/mcpct_params.svh
// timer constants: field widths, reset values and encodings as macros
// assumes inclusion by bare name from logic/
`ifndef MCPCT_PARAMS_SVH
`define MCPCT_PARAMS_SVH
`define MCPCT_CNT_W        32
`define MCPCT_PSC_W        16
`define MCPCT_NCH          4
`define MCPCT_DT_W         8
`define MCPCT_CNT_RST      32'h00000000
`define MCPCT_ARR_RST      32'hFFFFFFFF
`define MCPCT_PSC_RST      16'h0000
`define MCPCT_CLK_MHZ      10
`define MCPCT_CLK_NS       100
`define MCPCT_MODE_IDLE    3'h0
`define MCPCT_MODE_CAPT    3'h1
`define MCPCT_MODE_OCMP    3'h2
`define MCPCT_MODE_PWM     3'h3
`define MCPCT_MODE_PULSE   3'h4
`define MCPCT_DIR_UP       2'h0
`define MCPCT_DIR_DOWN     2'h1
`define MCPCT_DIR_CENTER   2'h2
`define MCPCT_SLV_OFF      2'h0
`define MCPCT_SLV_GATE     2'h1
`define MCPCT_SLV_START    2'h2
`define MCPCT_SLV_CLOCK    2'h3
`define MCPCT_CLK_INT      2'h0
`define MCPCT_CLK_QUAD     2'h1
`define MCPCT_CLK_HALL     2'h2
`endif

//--- logic/mcpct_pkg.sv
// timer types shared by the top and the channel module
// assumes mcpct_params.svh is on the include path
`include "mcpct_params.svh"
package mcpct_pkg;
  typedef logic [`MCPCT_CNT_W-1:0] mcpct_cnt_t;
  typedef logic [2:0]              mcpct_mode_t;
  typedef enum logic [1:0] {
    MCPCT_ST_STOP  = 2'h0,
    MCPCT_ST_RUN   = 2'h1,
    MCPCT_ST_DONE  = 2'h3
  } mcpct_state_t;
endpackage

//--- logic/mcpct_channel.sv
// one capture/compare channel with complementary output and dead time
// assumes cap_in is already synchronised to CLK_IN
`timescale 1ns/1ns
`default_nettype none
`include "mcpct_params.svh"
module mcpct_channel
  import mcpct_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic [2:0]             mode,
  input  wire logic                   cap_pol,
  input  wire logic                   cap_in,
  input  wire logic [`MCPCT_CNT_W-1:0] cnt,
  input  wire logic [`MCPCT_CNT_W-1:0] cmp,
  input  wire logic                   tick,
  input  wire logic [`MCPCT_DT_W-1:0] dead,
  input  wire logic                   comp_en,
  output logic      [`MCPCT_CNT_W-1:0] capt,
  output logic                        event_p,
  output logic                        out_p,
  output logic                        out_n
);
  logic                  cap_prev;
  logic                  ref_lvl;
  logic                  ref_prev;
  logic [`MCPCT_DT_W-1:0] dcnt;
  logic                  edge_seen;

  assign edge_seen = (cap_in ^ cap_pol) & ~(cap_prev ^ cap_pol);

  // ====================================================================
  // capture and compare
  always_ff @(posedge clk) begin
    if (rst) begin
      cap_prev <= 1'b0;
      capt     <= `MCPCT_CNT_RST;
      event_p  <= 1'b0;
    end else begin
      cap_prev <= cap_in;
      event_p  <= 1'b0;
      if (mode == `MCPCT_MODE_CAPT && edge_seen) begin
        capt    <= cnt; // R3
        event_p <= 1'b1;
      end else if (mode != `MCPCT_MODE_CAPT && mode != `MCPCT_MODE_IDLE && tick && cnt == cmp) begin
        event_p <= 1'b1;
      end
    end
  end

  // ====================================================================
  // reference waveform
  always_ff @(posedge clk) begin
    if (rst) begin
      ref_lvl <= 1'b0;
    end else begin
      unique case (mode)
        `MCPCT_MODE_PWM, `MCPCT_MODE_PULSE: ref_lvl <= (cnt < cmp); // R4 R7
        `MCPCT_MODE_OCMP: if (tick && cnt == cmp) ref_lvl <= ~ref_lvl; // R3
        default:          ref_lvl <= 1'b0;
      endcase
    end
  end

  // ====================================================================
  // dead time: both outputs low until dead cycles pass after a ref change
  always_ff @(posedge clk) begin
    if (rst) begin
      ref_prev <= 1'b0;
      dcnt     <= '0;
      out_p    <= 1'b0;
      out_n    <= 1'b0;
    end else begin
      ref_prev <= ref_lvl;
      if (ref_lvl != ref_prev) begin
        // the change edge is itself the first dead cycle
        dcnt  <= (dead == '0) ? '0 : dead - 1'b1; // R5
        out_p <= (dead == '0) & ref_lvl;
        out_n <= (dead == '0) & ~ref_lvl & comp_en;
      end else if (dcnt != '0) begin
        dcnt  <= dcnt - 1'b1;
        out_p <= 1'b0;
        out_n <= 1'b0;
      end else begin
        out_p <= ref_lvl;
        out_n <= ~ref_lvl & comp_en; // R5 R6
      end
    end
  end
endmodule
`default_nettype wire

//--- logic/mcpct_top.sv
// multi channel pwm and capture timer top: prescaler, counter, slave and encoder
// assumes pins are asynchronous, controls come from logic on CLK_IN
// Functional notes
// R1 - the counter is 16 or 32 bits wide and counts up, down or up then down.
// R2 - a prescaler divides the clock by any factor from 1 to 65536.
// R3 - four channels each do capture, compare, pwm or one pulse.
// R4 - pwm is edge aligned, or centre aligned when counting up and down.
// R5 - the advanced variant drives complements with programmable dead time.
// R6 - three phases and their complements can appear on six outputs.
// R7 - duty runs from fully off to fully on inclusive.
// R8 - the counter holds while the cpu is halted in debug if freezing is set.
// R9 - trigger in and out let timers start, gate or clock one another.
// R10 - the timer raises its own dma request on timer events.
// R11 - quadrature encoder inputs count up or down by their phase.
// R12 - one to four hall sensor inputs can clock the counter and be captured; the code takes three, HALL_IN[2:0].
// R13 - a reduced variant is a 16-bit upcounter with one or two channels.
// R14 - the basic variant makes a trigger out for converters and waveforms.
// R15 - overflow or underflow reloads from auto reload and marks an update.
// R16 - one pulse mode stops the counter after the first update.
`timescale 1ns/1ns
`default_nettype none
`include "mcpct_params.svh"
module mcpct_top
  import mcpct_pkg::*;
(
  input  wire logic                      CLK_IN,
  input  wire logic                      SYS_RST_IN,
  input  wire logic                      ENABLE_IN,
  input  wire logic                      WIDE_IN,
  input  wire logic [1:0]                DIR_MODE_IN,
  input  wire logic [1:0]                CLK_SRC_IN,
  input  wire logic [1:0]                SLAVE_MODE_IN,
  input  wire logic                      ONE_PULSE_IN,
  input  wire logic                      DEBUG_FREEZE_IN,
  input  wire logic                      DEBUG_HALT_IN,
  input  wire logic                      COMP_EN_IN,
  input  wire logic                      DMA_EN_IN,
  input  wire logic [15:0]               PRESCALE_IN,
  input  wire logic [`MCPCT_CNT_W-1:0]   RELOAD_IN,
  input  wire logic [`MCPCT_DT_W-1:0]    DEAD_TIME_IN,
  input  wire logic [11:0]               CH_MODE_IN,
  input  wire logic [3:0]                CAP_POL_IN,
  input  wire logic [4*`MCPCT_CNT_W-1:0] CMP_IN,
  input  wire logic [3:0]                CAP_PIN_IN,
  input  wire logic                      ENC_A_IN,
  input  wire logic                      ENC_B_IN,
  input  wire logic [2:0]                HALL_IN,
  input  wire logic                      TRIG_IN,
  input  wire logic                      DMA_ACK_IN,
  output logic      [`MCPCT_CNT_W-1:0]   COUNT_OUT,
  output logic      [4*`MCPCT_CNT_W-1:0] CAPT_OUT,
  output logic      [3:0]                PWM_OUT,
  output logic      [3:0]                PWM_N_OUT,
  output logic                           UPDATE_OUT,
  output logic                           TRIG_OUT,
  output logic                           DMA_REQ_OUT,
  output logic                           RUNNING_OUT
);
  logic [3:0]        pin_s1, pin_s2;
  logic [5:0]        io_s1, io_s2;
  logic [5:0]        io_d;
  logic [15:0]       psc;
  mcpct_cnt_t        cnt, top;
  mcpct_state_t      state;
  logic              down;
  logic              tick;
  logic              src_step;
  logic              src_dir_dn;
  logic              trig_rise;
  logic              ovf;
  logic              gate_ok;
  logic              quad_step, quad_dn, hall_chg;
  logic [1:0]        sync_fill;
  logic              sync_ok;
  logic [3:0]        ch_evt;
  logic [3:0]        ch_p, ch_n;
  logic [4*`MCPCT_CNT_W-1:0] ch_capt;

  // ====================================================================
  // pin synchronisers; first stage is read only by the second
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      pin_s1 <= 4'h0;
      pin_s2 <= 4'h0;
      io_s1  <= 6'h00;
      io_s2  <= 6'h00;
      io_d   <= 6'h00;
      sync_fill <= 2'h0;
    end else begin
      if (!sync_ok) sync_fill <= sync_fill + 2'h1;
      pin_s1 <= CAP_PIN_IN;
      pin_s2 <= pin_s1;
      io_s1  <= {TRIG_IN, HALL_IN, ENC_B_IN, ENC_A_IN};
      io_s2  <= io_s1;
      io_d   <= io_s2;
    end
  end

  assign top = WIDE_IN ? RELOAD_IN : {16'h0000, RELOAD_IN[15:0]}; // R1 R13
  // edges masked until the delayed stage holds pin data, so reset cannot fake one
  assign sync_ok   = (sync_fill == 2'h3);
  assign trig_rise = sync_ok & io_s2[5] & ~io_d[5];
  // x4 quadrature: direction from which phase moved against the other
  assign quad_step = sync_ok & ((io_s2[0] ^ io_d[0]) | (io_s2[1] ^ io_d[1]));
  assign quad_dn   = (io_s2[0] ^ io_d[1]) ^ 1'b1; // R11
  assign hall_chg  = sync_ok & (|(io_s2[4:2] ^ io_d[4:2])); // R12

  always_comb begin
    src_dir_dn = (DIR_MODE_IN == `MCPCT_DIR_DOWN);
    unique case (CLK_SRC_IN)
      `MCPCT_CLK_QUAD: begin
        src_step   = quad_step; // R11
        src_dir_dn = quad_dn;
      end
      `MCPCT_CLK_HALL: src_step = hall_chg; // R12
      default:         src_step = (SLAVE_MODE_IN == `MCPCT_SLV_CLOCK) ? trig_rise : 1'b1; // R9
    endcase
  end

  assign gate_ok = (SLAVE_MODE_IN != `MCPCT_SLV_GATE) | io_s2[5]; // R9

  // ====================================================================
  // run control: start by enable, which in start slave mode also waits for a trigger in rise; one pulse halts at update
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      state <= MCPCT_ST_STOP;
    end else begin
      unique case (state)
        MCPCT_ST_STOP: if (ENABLE_IN && (SLAVE_MODE_IN != `MCPCT_SLV_START || trig_rise)) state <= MCPCT_ST_RUN;
        MCPCT_ST_RUN: begin
          if (!ENABLE_IN) state <= MCPCT_ST_STOP;
          else if (ONE_PULSE_IN && ovf) state <= MCPCT_ST_DONE; // R16
        end
        MCPCT_ST_DONE: if (!ENABLE_IN) state <= MCPCT_ST_STOP;
        default: state <= MCPCT_ST_STOP;
      endcase
    end
  end

  // ====================================================================
  // prescaler: divide factor is PRESCALE_IN plus one
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      psc <= `MCPCT_PSC_RST;
    end else if (state == MCPCT_ST_RUN && gate_ok && src_step && !(DEBUG_FREEZE_IN && DEBUG_HALT_IN)) begin
      psc <= (psc >= PRESCALE_IN) ? 16'h0000 : psc + 16'h0001; // R2 R8
    end
  end

  assign tick = (state == MCPCT_ST_RUN) && gate_ok && src_step && !(DEBUG_FREEZE_IN && DEBUG_HALT_IN)
                && (psc >= PRESCALE_IN); // R2 R8
  assign ovf = tick && (down ? (cnt == '0) : (cnt >= top));

  // ====================================================================
  // counter with reload; centre mode turns at the ends
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      cnt  <= `MCPCT_CNT_RST;
      down <= 1'b0;
    end else if (tick) begin
      if (DIR_MODE_IN == `MCPCT_DIR_CENTER) begin
        if (!down && cnt >= top) begin
          down <= 1'b1;
          cnt  <= top - 1'b1; // R4
        end else if (down && cnt == '0) begin
          down <= 1'b0;
          cnt  <= 32'h00000001;
        end else begin
          cnt <= down ? cnt - 1'b1 : cnt + 1'b1;
        end
      end else begin
        down <= src_dir_dn; // R1
        if (src_dir_dn) cnt <= (cnt == '0) ? top : cnt - 1'b1; // R15
        else            cnt <= (cnt >= top) ? '0 : cnt + 1'b1; // R15
      end
    end
  end

  // ====================================================================
  // channels
  genvar gi;
  generate
    for (gi = 0; gi < `MCPCT_NCH; gi++) begin : g_ch
      mcpct_channel u_ch (
        .clk     (CLK_IN),
        .rst     (SYS_RST_IN),
        .mode    (CH_MODE_IN[3*gi +: 3]),
        .cap_pol (CAP_POL_IN[gi]),
        .cap_in  (gi == 0 && CLK_SRC_IN == `MCPCT_CLK_HALL ? hall_chg : pin_s2[gi]),
        .cnt     (cnt),
        .cmp     (CMP_IN[`MCPCT_CNT_W*gi +: `MCPCT_CNT_W]),
        .tick    (tick),
        .dead    (DEAD_TIME_IN),
        .comp_en (COMP_EN_IN),
        .capt    (ch_capt[`MCPCT_CNT_W*gi +: `MCPCT_CNT_W]),
        .event_p (ch_evt[gi]),
        .out_p   (ch_p[gi]),
        .out_n   (ch_n[gi])
      ); // R3 R5 R6 R12
    end
  endgenerate

  // ====================================================================
  // outputs, all registered; dma request holds until acknowledged
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      COUNT_OUT   <= `MCPCT_CNT_RST;
      CAPT_OUT    <= '0;
      PWM_OUT     <= 4'h0;
      PWM_N_OUT   <= 4'h0;
      UPDATE_OUT  <= 1'b0;
      TRIG_OUT    <= 1'b0;
      DMA_REQ_OUT <= 1'b0;
      RUNNING_OUT <= 1'b0;
    end else begin
      COUNT_OUT   <= cnt;
      CAPT_OUT    <= ch_capt;
      PWM_OUT     <= ch_p;
      PWM_N_OUT   <= ch_n;
      UPDATE_OUT  <= ovf; // R15
      TRIG_OUT    <= ovf; // R9 R14
      RUNNING_OUT <= (state == MCPCT_ST_RUN);
      // set wins over acknowledge so no event is lost
      if (DMA_EN_IN && (ovf || |ch_evt)) DMA_REQ_OUT <= 1'b1; // R10
      else if (DMA_ACK_IN)               DMA_REQ_OUT <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- testbench/mcpct_checker.sv
// concurrent checks on the timer top ports
// assumes one clock domain, bound to every mcpct_top instance
`timescale 1ns/1ns
`default_nettype none
`include "mcpct_params.svh"
module mcpct_checker (
  input wire logic          CLK_IN, SYS_RST_IN, ENABLE_IN, WIDE_IN, ONE_PULSE_IN,
  input wire logic          DEBUG_FREEZE_IN, DEBUG_HALT_IN, COMP_EN_IN, DMA_EN_IN, DMA_ACK_IN,
  input wire logic [1:0]    DIR_MODE_IN, CLK_SRC_IN, SLAVE_MODE_IN,
  input wire logic [15:0]   PRESCALE_IN,
  input wire logic [31:0]   RELOAD_IN, COUNT_OUT,
  input wire logic [7:0]    DEAD_TIME_IN,
  input wire logic [11:0]   CH_MODE_IN,
  input wire logic [127:0]  CMP_IN,
  input wire logic [3:0]    PWM_OUT, PWM_N_OUT,
  input wire logic          UPDATE_OUT, TRIG_OUT, DMA_REQ_OUT, RUNNING_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  // ==========================================
  // helpers
  logic frz, cfg3, top_ok;
  assign frz = DEBUG_FREEZE_IN && DEBUG_HALT_IN;
  assign cfg3 = ENABLE_IN && WIDE_IN && PRESCALE_IN == 16'h0000 && RELOAD_IN == 32'h00000002 && !frz
    && DIR_MODE_IN == `MCPCT_DIR_UP && SLAVE_MODE_IN == `MCPCT_SLV_OFF && CLK_SRC_IN == `MCPCT_CLK_INT && !ONE_PULSE_IN;
  assign top_ok = COUNT_OUT <= (WIDE_IN ? RELOAD_IN : {16'h0000, RELOAD_IN[15:0]});
  sequence gap_s;
    !UPDATE_OUT ##1 !UPDATE_OUT ##1 UPDATE_OUT;
  endsequence
  sequence start_s;
    $rose(ENABLE_IN) && !RUNNING_OUT && SLAVE_MODE_IN == `MCPCT_SLV_OFF;
  endsequence
  // ==========================================
  // assertions
  reset_clear_a: assert property ($fell(SYS_RST_IN) |-> COUNT_OUT == 32'h0 && PWM_OUT == 4'h0 && !RUNNING_OUT)
    else $error("outputs not cleared by reset");
  run_start_a: assert property (start_s |-> ##2 RUNNING_OUT) else $error("start latency wrong");
  upd_period_a: assert property (cfg3 [*3] ##0 UPDATE_OUT |=> gap_s) else $error("update period wrong");
  count_top_a: assert property (($stable(RELOAD_IN) && $stable(WIDE_IN)) [*3] |-> top_ok)
    else $error("count above reload");
  trig_upd_a: assert property (TRIG_OUT == UPDATE_OUT) else $error("trigger out differs from update");
  dma_hold_a: assert property (DMA_REQ_OUT && !DMA_ACK_IN && DMA_EN_IN |=> DMA_REQ_OUT)
    else $error("dma request dropped");
  freeze_hold_a: assert property (frz [*3] |-> $stable(COUNT_OUT)) else $error("count moved in debug");
  pulse_stop_a: assert property (ONE_PULSE_IN && ENABLE_IN && UPDATE_OUT |=> (COUNT_OUT == 32'h0) [*4])
    else $error("one pulse counter ran on");
  duty_off_a: assert property ((CH_MODE_IN[5:3] == `MCPCT_MODE_PWM && CMP_IN[63:32] == 32'h0) [*4] |-> !PWM_OUT[1])
    else $error("zero duty not off");
  duty_on_a: assert property ((CH_MODE_IN[8:6] == `MCPCT_MODE_PWM && CMP_IN[95:64] > RELOAD_IN && RUNNING_OUT
    && DEAD_TIME_IN < 8'h04) [*8] |-> PWM_OUT[2]) else $error("full duty not on");
  comp_excl_a: assert property ((PWM_OUT & PWM_N_OUT) == 4'h0) else $error("both outputs high");
  comp_gate_a: assert property (!COMP_EN_IN [*3] |-> PWM_N_OUT == 4'h0) else $error("complement not gated");
endmodule
bind mcpct_top mcpct_checker u_chk (.CLK_IN(CLK_IN), .SYS_RST_IN(SYS_RST_IN), .ENABLE_IN(ENABLE_IN),
  .WIDE_IN(WIDE_IN), .ONE_PULSE_IN(ONE_PULSE_IN), .DEBUG_FREEZE_IN(DEBUG_FREEZE_IN), .DEBUG_HALT_IN(DEBUG_HALT_IN),
  .COMP_EN_IN(COMP_EN_IN), .DMA_EN_IN(DMA_EN_IN), .DMA_ACK_IN(DMA_ACK_IN), .DIR_MODE_IN(DIR_MODE_IN),
  .CLK_SRC_IN(CLK_SRC_IN), .SLAVE_MODE_IN(SLAVE_MODE_IN), .PRESCALE_IN(PRESCALE_IN), .RELOAD_IN(RELOAD_IN),
  .COUNT_OUT(COUNT_OUT), .DEAD_TIME_IN(DEAD_TIME_IN), .CH_MODE_IN(CH_MODE_IN), .CMP_IN(CMP_IN), .PWM_OUT(PWM_OUT),
  .PWM_N_OUT(PWM_N_OUT), .UPDATE_OUT(UPDATE_OUT), .TRIG_OUT(TRIG_OUT), .DMA_REQ_OUT(DMA_REQ_OUT),
  .RUNNING_OUT(RUNNING_OUT));
`default_nettype wire

//--- testbench/mcpct_sensor_model.sv
// quadrature encoder and six step hall sensor model
// assumes one step request per pulse of step_in, sampled on clk_in
`timescale 1ns/1ns
`default_nettype none
module mcpct_sensor_model (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       step_in,
  input  wire logic       rev_in,
  output logic            enc_a_out,
  output logic            enc_b_out,
  output logic [2:0]      hall_out
);
  logic [1:0] phase;
  logic [2:0] pos;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      phase <= 2'h0;
      pos <= 3'h0;
    end else if (step_in) begin
      phase <= rev_in ? phase - 2'h1 : phase + 2'h1;
      pos <= rev_in ? (pos == 3'h0 ? 3'h5 : pos - 3'h1) : (pos == 3'h5 ? 3'h0 : pos + 3'h1);
    end
  end
  // gray order: only one encoder line moves per step
  assign enc_a_out = phase[1];
  assign enc_b_out = phase[1] ^ phase[0];
  always_comb begin
    case (pos)
      3'h0: hall_out = 3'h1;
      3'h1: hall_out = 3'h3;
      3'h2: hall_out = 3'h2;
      3'h3: hall_out = 3'h6;
      3'h4: hall_out = 3'h4;
      default: hall_out = 3'h5;
    endcase
  end
endmodule
`default_nettype wire

//--- testbench/mcpct_tb_top.sv
// self-checking bench for the timer top
// assumes the checker is bound by its own file and the sensor model sits on the pins
`timescale 1ns/1ns
`default_nettype none
`include "mcpct_params.svh"
module mcpct_tb_top;
  import mcpct_pkg::*;
`define CHK(nm, e, s) begin checked++; if ((s) !== (e)) begin n_fail++; \
  $display("wrong value %s expected %0h seen %0h", nm, e, s); end end
  typedef struct {logic [15:0] p; logic [31:0] r; logic [1:0] d; logic w; int e;} mcpct_row_t;
  logic clk = 0, rst = 1, en = 0, wide = 1, frz = 0, halt = 0, comp = 1, dma_en = 0, op = 0, ack = 0, trg = 0;
  logic [1:0] dir = 0, src = 0, slv = 0;
  logic [15:0] psc = 0;
  logic [31:0] rld = 2, c0, cnt;
  logic [7:0] dt = 0;
  logic [11:0] chm = 0;
  logic [127:0] cmp = 0, capt;
  logic [3:0] pwm, pwmn;
  logic upd, tro, dreq, run, step = 0, rev = 0, ea, eb, cap = 0;
  logic [2:0] hall;
  int n_fail = 0, checked = 0, nu, np, nn;
  // 120 cycles is a multiple of every period below, so phase does not matter
  mcpct_row_t rows [6] = '{'{16'h0, 32'h2, `MCPCT_DIR_UP, 1, 40}, '{16'h1, 32'h2, `MCPCT_DIR_UP, 1, 20},
    '{16'h2, 32'h3, `MCPCT_DIR_UP, 1, 10}, '{16'h0, 32'h3, `MCPCT_DIR_DOWN, 1, 30},
    '{16'h0, 32'h00010003, `MCPCT_DIR_UP, 0, 30}, '{16'h0, 32'h3, `MCPCT_DIR_CENTER, 1, 40}};
  always #50 clk = ~clk;
  mcpct_sensor_model u_sens (.clk_in(clk), .rst_in(rst), .step_in(step), .rev_in(rev), .enc_a_out(ea),
    .enc_b_out(eb), .hall_out(hall));
  mcpct_top DUT (.CLK_IN(clk), .SYS_RST_IN(rst), .ENABLE_IN(en), .WIDE_IN(wide), .DIR_MODE_IN(dir),
    .CLK_SRC_IN(src), .SLAVE_MODE_IN(slv), .ONE_PULSE_IN(op), .DEBUG_FREEZE_IN(frz), .DEBUG_HALT_IN(halt),
    .COMP_EN_IN(comp), .DMA_EN_IN(dma_en), .PRESCALE_IN(psc), .RELOAD_IN(rld), .DEAD_TIME_IN(dt),
    .CH_MODE_IN(chm), .CAP_POL_IN(4'h0), .CMP_IN(cmp), .CAP_PIN_IN({cap, 3'h0}), .ENC_A_IN(ea), .ENC_B_IN(eb),
    .HALL_IN(hall), .TRIG_IN(trg), .DMA_ACK_IN(ack), .COUNT_OUT(cnt), .CAPT_OUT(capt), .PWM_OUT(pwm),
    .PWM_N_OUT(pwmn), .UPDATE_OUT(upd), .TRIG_OUT(tro), .DMA_REQ_OUT(dreq), .RUNNING_OUT(run));
  // ==========================================
  // tasks
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic restart();
    rst = 1; en = 0; tick(5); rst = 0;
  endtask
  task automatic measure();
    nu = 0; np = 0; nn = 0;
    repeat (120) begin
      @(negedge clk);
      nu += (upd === 1'b1); np += (pwm[0] === 1'b1); nn += (pwmn[0] === 1'b1);
    end
  endtask
  task automatic steps(input int n, input logic r);
    rev = r;
    repeat (n) begin step = 1; tick(1); step = 0; tick(4); end
    tick(5);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #2000000; n_fail++; print_verdict();
  end
  // ==========================================
  // tests
  initial begin
    foreach (rows[i]) begin
      restart(); psc = rows[i].p; rld = rows[i].r; dir = rows[i].d; wide = rows[i].w; dma_en = 1; en = 1;
      tick(10); measure();
      `CHK("updates", rows[i].e, nu)
      `CHK("dma request", 1'b1, dreq)
    end
    restart(); dir = `MCPCT_DIR_UP; wide = 1; psc = 0; rld = 32'hFF; en = 1; tick(10);
    frz = 1; halt = 1; tick(3); c0 = cnt; tick(10);
    `CHK("frozen count", c0, cnt)
    halt = 0; tick(4);
    `CHK("count resumes", 1'b1, cnt != c0)
    restart(); slv = `MCPCT_SLV_GATE; en = 1; tick(10); c0 = cnt; tick(10);
    `CHK("gated count", c0, cnt)
    trg = 1; tick(10);
    `CHK("gate open", 1'b1, cnt != c0)
    restart(); slv = `MCPCT_SLV_OFF; op = 1; rld = 3; en = 1; tick(3); measure();
    `CHK("one pulse updates", 1, nu)
    ack = 1; tick(3);
    `CHK("dma ack", 1'b0, dreq)
    ack = 0; op = 0;
    restart(); dt = 1; chm = 12'h0DB; cmp = {32'h0, 32'h5, 32'h0, 32'h2}; en = 1; tick(10); measure();
    `CHK("pwm high", 30, np)
    `CHK("pwm low side", 30, nn)
    `CHK("duty extremes", 2'b10, pwm[2:1])
    comp = 0; tick(4);
    `CHK("complement gated", 4'h0, pwmn)
    restart(); src = `MCPCT_CLK_QUAD; rld = 32'hFFFF; en = 1; tick(10); c0 = cnt; steps(8, 0);
    // counting down from zero wraps through the 16-bit reload value
    `CHK("encoder forward", 1'b1, cnt == c0 + 32'h8 || cnt == 32'h0000FFF8)
    steps(8, 1);
    `CHK("encoder back", c0, cnt)
    restart(); src = `MCPCT_CLK_HALL; en = 1; tick(10); c0 = cnt; steps(6, 0);
    `CHK("hall steps", c0 + 32'h6, cnt)
    // count is k-1 after edge k; the pin edge reaches the channel two edges late
    restart(); src = `MCPCT_CLK_INT; rld = 32'hFF; chm = 12'h200; en = 1; tick(20); cap = 1; tick(5);
    `CHK("capture value", 32'h00000015, capt[127:96])
    `CHK("running", 1'b1, run)
    print_verdict();
  end
endmodule
`default_nettype wire
